// *** core/inc_dec_pkg.sv ***
/*
 * shared constants of the increment/decrement unit: register offsets, field positions,
 * operation codes and reset values.
 * assumes a 32-bit avalon-mm register bus with byte addresses.
 */
package inc_dec_pkg;
   // register byte offsets
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_OPERAND_LO = 5'h04;
   localparam logic [4:0] OFF_OPERAND_HI = 5'h08;
   localparam logic [4:0] OFF_FLAGS = 5'h0c;
   localparam logic [4:0] OFF_SCAN = 5'h10;
   localparam logic [4:0] OFF_IRQ_STATUS = 5'h14;
   localparam logic [4:0] OFF_IRQ_MASK = 5'h18;
   localparam logic [4:0] OFF_EXEC_COUNT = 5'h1c;
   // control register fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_EDGE_BIT = 16;
   localparam int CTRL_COND_BIT = 24;
   localparam logic [31:0] CTRL_WMASK = 32'h0101_03ff;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // operation codes
   localparam logic [9:0] OP_BIN_DEC = 10'h250;
   localparam logic [9:0] OP_BIN_DEC_DOUBLE = 10'h251;
   localparam logic [9:0] OP_BCD_INC = 10'h252;
   localparam logic [9:0] OP_BCD_INC_DOUBLE = 10'h253;
   localparam logic [9:0] OP_BCD_DEC = 10'h254;
   localparam logic [9:0] OP_BCD_DEC_DOUBLE = 10'h255;
   // flag and interrupt bit positions
   localparam int FLAG_ERROR = 0;
   localparam int FLAG_ZERO = 1;
   localparam int FLAG_CARRY = 2;
   localparam int FLAG_NEGATIVE = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERROR = 1;
   localparam int IRQ_ZERO = 2;
   localparam int IRQ_CARRY = 3;
   // reset values and masks
   localparam logic [15:0] OPERAND_RESET = 16'h0000;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
   localparam logic [7:0] DIGITS_SINGLE = 8'h0f;
   localparam logic [7:0] DIGITS_DOUBLE = 8'hff;
endpackage

// *** core/bin_decrement_unit.sv ***
/*
 * 32-bit binary decrement with per-nibble detection of a 0 to f change.
 * assumes the caller masks the nibbles that do not belong to the operand.
 */
`timescale 1ns/1ps
module bin_decrement_unit (
   // operand
   input wire logic [31:0] value,
   // result
   output logic [31:0] result,
   output logic [7:0] nibble_wrap
);
   assign result = value - 32'h0000_0001;

   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_nib
         assign nibble_wrap[i] = (value[4*i +: 4] == 4'h0) && (result[4*i +: 4] == 4'hf);
      end
   endgenerate
endmodule

// *** core/bcd_step_unit.sv ***
/*
 * eight-digit packed bcd step by one, up or down, with decimal carry or borrow.
 * assumes the caller masks digits beyond the operand width and checks validity itself.
 */
`timescale 1ns/1ps
module bcd_step_unit (
   // operand and direction
   input wire logic [31:0] value,
   input wire logic count_up,
   // result
   output logic [31:0] result,
   output logic [7:0] digit_wrap,
   output logic [7:0] digit_bad
);
   logic [8:0] ripple;

   assign ripple[0] = 1'b1;

   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_dig
         wire [3:0] d = value[4*i +: 4];
         wire at_edge = count_up ? (d == 4'h9) : (d == 4'h0);
         assign digit_bad[i] = d > 4'h9;
         assign digit_wrap[i] = ripple[i] & at_edge;
         assign ripple[i+1] = ripple[i] & at_edge;
         // a stepped digit either wraps to its far end or moves by one
         assign result[4*i +: 4] = !ripple[i] ? d :
                                   at_edge ? (count_up ? 4'h0 : 4'h9) :
                                   (count_up ? d + 4'h1 : d - 4'h1);
      end
   endgenerate
endmodule

// *** core/inc_dec_binary_bcd_unit.sv ***
/*
 * increment/decrement execution unit: binary decrement and bcd increment/decrement
 * of one word or a word pair, with error, zero, carry and negative flags,
 * an avalon-mm register slave with waitrequest and a masked level interrupt.
 * assumes software drives the operation code, operands and execution condition,
 * and writes the scan register once per scan cycle.
 */
`timescale 1ns/1ps
module inc_dec_binary_bcd_unit (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // interrupt
   output logic irq,
   // condition flags
   output logic error_flag,
   output logic zero_result_flag,
   output logic digit_carry_flag,
   output logic negative_flag
);
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } bus_state_t;

   // reset synchroniser
   logic rst_meta_reg;
   logic rst_sync_reg;
   wire rst_n = rst_sync_reg;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // bus handshake: every access answers in its second cycle
   bus_state_t state_reg;
   bus_state_t state_next;
   wire req = avs_read | avs_write;

   always_comb begin
      case (state_reg)
         BUS_IDLE: state_next = req ? BUS_ACK : BUS_IDLE;
         BUS_ACK: state_next = BUS_IDLE;
         default: state_next = BUS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= BUS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   wire accept = req & (state_reg == BUS_ACK);
   wire rd_capture = avs_read & (state_reg == BUS_IDLE);
   wire wr_acc = avs_write & accept;
   wire rd_acc = avs_read & accept;
   assign avs_waitrequest = req & (state_reg != BUS_ACK);

   // address decode
   wire [4:0] addr_word = {avs_address[4:2], 2'b00};
   wire sel_ctrl = addr_word == inc_dec_pkg::OFF_CTRL;
   wire sel_lo = addr_word == inc_dec_pkg::OFF_OPERAND_LO;
   wire sel_hi = addr_word == inc_dec_pkg::OFF_OPERAND_HI;
   wire sel_flags = addr_word == inc_dec_pkg::OFF_FLAGS;
   wire sel_scan = addr_word == inc_dec_pkg::OFF_SCAN;
   wire sel_irq_status = addr_word == inc_dec_pkg::OFF_IRQ_STATUS;
   wire sel_irq_mask = addr_word == inc_dec_pkg::OFF_IRQ_MASK;
   wire sel_count = addr_word == inc_dec_pkg::OFF_EXEC_COUNT;
   wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // register state
   logic [31:0] ctrl_reg;
   logic [15:0] operand_lo_reg;
   logic [15:0] operand_hi_reg;
   logic [3:0] flags_reg;
   logic [3:0] irq_status_reg;
   logic [3:0] irq_mask_reg;
   logic cond_prev_reg;
   logic [15:0] exec_count_reg;
   logic [31:0] readdata_reg;

   // operation decode
   wire [9:0] opcode = ctrl_reg[inc_dec_pkg::CTRL_OP_LSB +: 10];
   wire op_bin16 = opcode == inc_dec_pkg::OP_BIN_DEC;
   wire op_bin32 = opcode == inc_dec_pkg::OP_BIN_DEC_DOUBLE;
   wire op_inc16 = opcode == inc_dec_pkg::OP_BCD_INC;
   wire op_inc32 = opcode == inc_dec_pkg::OP_BCD_INC_DOUBLE;
   wire op_dec16 = opcode == inc_dec_pkg::OP_BCD_DEC;
   wire op_dec32 = opcode == inc_dec_pkg::OP_BCD_DEC_DOUBLE;
   wire is_double = op_bin32 | op_inc32 | op_dec32;
   wire is_bcd = op_inc16 | op_inc32 | op_dec16 | op_dec32;
   wire is_bcd_up = op_inc16 | op_inc32;
   wire valid_op = op_bin16 | op_bin32 | is_bcd;
   wire [7:0] digit_mask = is_double ? inc_dec_pkg::DIGITS_DOUBLE : inc_dec_pkg::DIGITS_SINGLE;

   // the following word is the upper half of a pair
   wire [31:0] operand = is_double ? {operand_hi_reg, operand_lo_reg} : {16'h0000, operand_lo_reg};

   // datapaths
   wire [31:0] bin_result;
   wire [7:0] bin_wrap;
   wire [31:0] bcd_result;
   wire [7:0] bcd_wrap;
   wire [7:0] bcd_bad;

   bin_decrement_unit u_bin (
      .value(operand),
      .result(bin_result),
      .nibble_wrap(bin_wrap)
   );

   bcd_step_unit u_bcd (
      .value(operand),
      .count_up(is_bcd_up),
      .result(bcd_result),
      .digit_wrap(bcd_wrap),
      .digit_bad(bcd_bad)
   );

   wire bad_digit = is_bcd & (|(bcd_bad & digit_mask));
   // a bad operand is kept as it was so software can repair it
   wire [31:0] raw_value = bad_digit ? operand : (is_bcd ? bcd_result : bin_result);
   wire [31:0] new_value = is_double ? raw_value : {16'h0000, raw_value[15:0]};
   wire new_zero = new_value == 32'h0000_0000;
   wire bcd_carry = ~bad_digit & (|(bcd_wrap & digit_mask));
   wire bin_carry = |(bin_wrap & digit_mask);
   wire new_carry = is_bcd ? bcd_carry : bin_carry;
   wire new_negative = is_double ? new_value[31] : new_value[15];

   // scan cycle and execution condition
   wire scan_go = wr_acc & sel_scan & avs_byteenable[0] & avs_writedata[0];
   wire cond = ctrl_reg[inc_dec_pkg::CTRL_COND_BIT];
   wire edge_mode = ctrl_reg[inc_dec_pkg::CTRL_EDGE_BIT];
   wire cond_rose = cond & ~cond_prev_reg;
   wire fire = scan_go & (edge_mode ? cond_rose : cond);
   wire exec = fire & valid_op;
   wire write_back = exec & ~bad_digit;

   // interrupt events; a set in the cycle of the clearing read wins
   wire [3:0] irq_events = {exec & new_carry, exec & new_zero, exec & bad_digit, exec};
   wire irq_clear = rd_acc & sel_irq_status;
   wire [3:0] irq_status_next = (irq_status_reg & ~{4{irq_clear}}) | irq_events;

   // register write data
   wire [31:0] ctrl_next = (ctrl_reg & ~(be_mask & inc_dec_pkg::CTRL_WMASK)) |
                           (avs_writedata & be_mask & inc_dec_pkg::CTRL_WMASK);
   wire [15:0] lo_bus = (operand_lo_reg & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
   wire [15:0] hi_bus = (operand_hi_reg & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
   wire [3:0] mask_bus = (irq_mask_reg & ~be_mask[3:0]) | (avs_writedata[3:0] & be_mask[3:0]);
   wire [15:0] operand_lo_next = write_back ? new_value[15:0] : (wr_acc & sel_lo) ? lo_bus : operand_lo_reg;
   wire [15:0] operand_hi_next = (write_back & is_double) ? new_value[31:16] :
                                 (wr_acc & sel_hi) ? hi_bus : operand_hi_reg;
   // binary operations always clear error; bcd ones leave negative as it was
   wire [3:0] flags_next = {is_bcd ? flags_reg[inc_dec_pkg::FLAG_NEGATIVE] : new_negative,
                            new_carry, new_zero, bad_digit};

   // read multiplexer; unmapped offsets read zero
   wire [31:0] read_mux = sel_ctrl ? ctrl_reg :
                          sel_lo ? {16'h0000, operand_lo_reg} :
                          sel_hi ? {16'h0000, operand_hi_reg} :
                          sel_flags ? {28'h0000000, flags_reg} :
                          sel_irq_status ? {28'h0000000, irq_status_reg} :
                          sel_irq_mask ? {28'h0000000, irq_mask_reg} :
                          sel_count ? {16'h0000, exec_count_reg} :
                          32'h0000_0000;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= inc_dec_pkg::CTRL_RESET;
      end else if (wr_acc & sel_ctrl) begin
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         operand_lo_reg <= inc_dec_pkg::OPERAND_RESET;
         operand_hi_reg <= inc_dec_pkg::OPERAND_RESET;
      end else begin
         operand_lo_reg <= operand_lo_next;
         operand_hi_reg <= operand_hi_next;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg <= inc_dec_pkg::FLAGS_RESET;
      end else if (exec) begin
         flags_reg <= flags_next;
      end
   end

   // the previous condition advances only at scans, as the sequencer sees it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_prev_reg <= 1'b0;
      end else if (scan_go) begin
         cond_prev_reg <= cond;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         exec_count_reg <= 16'h0000;
      end else if (write_back) begin
         exec_count_reg <= exec_count_reg + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status_reg <= 4'h0;
         irq_mask_reg <= inc_dec_pkg::IRQ_MASK_RESET;
      end else begin
         irq_status_reg <= irq_status_next;
         if (wr_acc & sel_irq_mask) begin
            irq_mask_reg <= mask_bus;
         end
      end
   end

   // read data is caught in the first cycle and stands through the answer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata_reg <= 32'h0000_0000;
      end else if (rd_capture) begin
         readdata_reg <= read_mux;
      end
   end

   assign avs_readdata = readdata_reg;
   assign irq = |(irq_status_reg & irq_mask_reg);
   assign error_flag = flags_reg[inc_dec_pkg::FLAG_ERROR];
   assign zero_result_flag = flags_reg[inc_dec_pkg::FLAG_ZERO];
   assign digit_carry_flag = flags_reg[inc_dec_pkg::FLAG_CARRY];
   assign negative_flag = flags_reg[inc_dec_pkg::FLAG_NEGATIVE];
endmodule

// *** dv/inc_dec_binary_bcd_unit_assertions.sv ***
/* checker for the increment/decrement unit: bus handshake, flag and interrupt relations.
   assumes it is bound to the unit's top module and sees only its ports. */
`timescale 1ns/1ps
module inc_dec_binary_bcd_unit_assertions (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // register bus
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // interrupt and flags
   input wire logic irq,
   input wire logic error_flag,
   input wire logic zero_result_flag,
   input wire logic digit_carry_flag,
   input wire logic negative_flag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   wire logic req = avs_read | avs_write;
   wire logic answer = req & ~avs_waitrequest;
   // the byte lane and bit0 must both be set, otherwise the scan write is a no-op
   wire logic scan_take = avs_write & answer & (avs_address == inc_dec_pkg::OFF_SCAN) & avs_byteenable[0]
      & avs_writedata[0];
   wire logic [3:0] flags = {negative_flag, digit_carry_flag, zero_result_flag, error_flag};
   sequence s_wait;
      req && avs_waitrequest;
   endsequence
   sequence s_answer;
      answer;
   endsequence
   a_wait_one_cycle: assert property (s_wait |=> s_answer) else $error("access not answered after one wait");
   a_idle_no_wait: assert property (!req |-> !avs_waitrequest) else $error("waitrequest high while idle");
   a_answer_then_wait: assert property (s_answer ##1 req |-> avs_waitrequest) else $error("new access not held");
   a_irq_read_clear: assert property (avs_read && answer && avs_address == inc_dec_pkg::OFF_IRQ_STATUS |=> !irq)
      else $error("irq still high after status read");
   a_flags_on_scan: assert property (!scan_take |=> $stable(flags)) else $error("flags moved without scan");
   a_error_no_carry: assert property (error_flag |-> !digit_carry_flag) else $error("carry set with error");
   a_flags_readback: assert property (avs_read && answer && avs_address == inc_dec_pkg::OFF_FLAGS
      |-> avs_readdata[3:0] == flags) else $error("flag register differs from flag pins");
   a_readdata_stands: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data changed outside a read");
endmodule
bind inc_dec_binary_bcd_unit inc_dec_binary_bcd_unit_assertions i_chk (.ref_clk(ref_clk), .nrst(nrst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
   .error_flag(error_flag), .zero_result_flag(zero_result_flag), .digit_carry_flag(digit_carry_flag),
   .negative_flag(negative_flag));

// *** dv/sequencer_bus_model.sv ***
/* program sequencer model: avalon-mm master issuing one access at a time.
   assumes the slave answers by dropping waitrequest; a stuck slave raises bus_timeout. */
`timescale 1ns/1ps
module sequencer_bus_model (
   // clock
   input wire logic ref_clk,
   // avalon-mm master
   output logic [4:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [3:0] avs_byteenable,
   output logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // status
   output logic bus_timeout
);
   initial begin
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'h0;
      avs_writedata = 32'h0;
      bus_timeout = 1'b0;
   end
   // an idle edge follows every access so no strobe is assigned twice in one time step
   task automatic access(input logic wr, input logic [4:0] addr, input logic [31:0] wdata,
      output logic [31:0] rdata);
      int n;
      n = 0;
      avs_address <= addr;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= wdata;
      avs_byteenable <= 4'hf;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rdata = avs_readdata;
      if (avs_waitrequest !== 1'b0) bus_timeout <= 1'b1;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
endmodule

// *** dv/inc_dec_binary_bcd_unit_tb_top.sv ***
/* self-checking bench for the increment/decrement unit, driving registers through the sequencer model.
   assumes one 100 MHz clock and the register map of the unit's package. */
`timescale 1ns/1ps
module inc_dec_binary_bcd_unit_tb_top;
   logic ref_clk, nrst, irq, err_f, zero_f, carry_f, neg_f, rd_wait, rd_req, wr_req, bus_timeout;
   logic [4:0] addr;
   logic [3:0] be;
   logic [31:0] wdata, rdata, rd;
   int errors, checks_done;
   wire logic [31:0] flags_now = {28'h0, neg_f, carry_f, zero_f, err_f};
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   inc_dec_binary_bcd_unit i_dut (.ref_clk(ref_clk), .nrst(nrst), .avs_address(addr), .avs_read(rd_req),
      .avs_write(wr_req), .avs_byteenable(be), .avs_writedata(wdata), .avs_readdata(rdata),
      .avs_waitrequest(rd_wait), .irq(irq), .error_flag(err_f), .zero_result_flag(zero_f),
      .digit_carry_flag(carry_f), .negative_flag(neg_f));
   sequencer_bus_model i_seq (.ref_clk(ref_clk), .avs_address(addr), .avs_read(rd_req), .avs_write(wr_req),
      .avs_byteenable(be), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(rd_wait),
      .bus_timeout(bus_timeout));
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [4:0] a, logic [31:0] d);
      i_seq.access(1'b1, a, d, rd);
   endtask
   task automatic rdchk(string what, logic [4:0] a, logic [31:0] exp);
      i_seq.access(1'b0, a, 32'h0, rd);
      check_val(what, exp, rd);
   endtask
   task automatic ctrl(logic [9:0] op, logic edge_form, logic cond);
      wr(inc_dec_pkg::OFF_CTRL, {7'h0, cond, 7'h0, edge_form, 6'h0, op});
   endtask
   // level form, one scan, then operands and flags compared; fmask hides flags the op keeps
   task automatic step(logic [9:0] op, logic [15:0] lo, logic [15:0] hi, logic [15:0] elo, logic [15:0] ehi,
      logic [3:0] ef, logic [3:0] fmask);
      ctrl(op, 1'b0, 1'b1);
      wr(inc_dec_pkg::OFF_OPERAND_LO, {16'h0, lo});
      wr(inc_dec_pkg::OFF_OPERAND_HI, {16'h0, hi});
      wr(inc_dec_pkg::OFF_SCAN, 32'h1);
      rdchk("operand_lo", inc_dec_pkg::OFF_OPERAND_LO, {16'h0, elo});
      rdchk("operand_hi", inc_dec_pkg::OFF_OPERAND_HI, {16'h0, ehi});
      check_val("flags", {28'h0, ef & fmask}, flags_now & {28'h0, fmask});
   endtask
   task automatic t_reset;
      for (int i = 0; i < 8; i++) if (i != 4) rdchk("reset value", 5'(i * 4), 32'h0);
      $display("test reset done");
   endtask
   task automatic t_binary;
      step(10'd592, 16'h1000, 16'h0000, 16'h0fff, 16'h0000, 4'b0100, 4'hf);
      step(10'd592, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 4'b0010, 4'hf);
      step(10'd592, 16'h0000, 16'h1234, 16'hffff, 16'h1234, 4'b1100, 4'hf);
      step(10'd593, 16'h0000, 16'h0001, 16'hffff, 16'h0000, 4'b0100, 4'hf);
      step(10'd593, 16'h0000, 16'h0000, 16'hffff, 16'hffff, 4'b1100, 4'hf);
      step(10'd593, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 4'b0010, 4'hf);
      $display("test binary done");
   endtask
   task automatic t_bcd;
      step(10'd594, 16'h0999, 16'h0000, 16'h1000, 16'h0000, 4'b0100, 4'h7);
      step(10'd594, 16'h9999, 16'h0000, 16'h0000, 16'h0000, 4'b0110, 4'h7);
      step(10'd594, 16'h0123, 16'h0000, 16'h0124, 16'h0000, 4'b0000, 4'h7);
      step(10'd595, 16'h9999, 16'h0000, 16'h0000, 16'h0001, 4'b0100, 4'h7);
      step(10'd595, 16'h9999, 16'h9999, 16'h0000, 16'h0000, 4'b0110, 4'h7);
      step(10'd596, 16'h1000, 16'h0000, 16'h0999, 16'h0000, 4'b0100, 4'h7);
      step(10'd596, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 4'b0010, 4'h7);
      step(10'd597, 16'h0000, 16'h0001, 16'h9999, 16'h0000, 4'b0100, 4'h7);
      step(10'd597, 16'h0000, 16'h0000, 16'h9999, 16'h9999, 4'b0100, 4'h7);
      $display("test bcd done");
   endtask
   task automatic t_invalid_irq;
      i_seq.access(1'b0, inc_dec_pkg::OFF_IRQ_STATUS, 32'h0, rd);
      wr(inc_dec_pkg::OFF_IRQ_MASK, 32'h2);
      step(10'd597, 16'h0000, 16'h00b0, 16'h0000, 16'h00b0, 4'b0001, 4'h7);
      step(10'd594, 16'h00a0, 16'h0000, 16'h00a0, 16'h0000, 4'b0001, 4'h7);
      check_val("irq raised", 32'h1, {31'h0, irq});
      rdchk("irq status", inc_dec_pkg::OFF_IRQ_STATUS, 32'h3);
      check_val("irq cleared", 32'h0, {31'h0, irq});
      wr(inc_dec_pkg::OFF_FLAGS, 32'hf);
      rdchk("flags read only", inc_dec_pkg::OFF_FLAGS, 32'h1);
      wr(inc_dec_pkg::OFF_IRQ_MASK, 32'h0);
      step(10'd596, 16'h00c0, 16'h0000, 16'h00c0, 16'h0000, 4'b0001, 4'h7);
      check_val("irq masked", 32'h0, {31'h0, irq});
      $display("test invalid and irq done");
   endtask
   task automatic t_level_edge;
      step(10'd592, 16'h0010, 16'h0000, 16'h000f, 16'h0000, 4'b0100, 4'hf);
      wr(inc_dec_pkg::OFF_SCAN, 32'h1);
      wr(inc_dec_pkg::OFF_SCAN, 32'h1);
      rdchk("level repeats", inc_dec_pkg::OFF_OPERAND_LO, 32'h000d);
      ctrl(10'd592, 1'b1, 1'b1);
      wr(inc_dec_pkg::OFF_SCAN, 32'h1);
      rdchk("edge held on", inc_dec_pkg::OFF_OPERAND_LO, 32'h000d);
      ctrl(10'd592, 1'b1, 1'b0);
      wr(inc_dec_pkg::OFF_SCAN, 32'h1);
      ctrl(10'd592, 1'b1, 1'b1);
      wr(inc_dec_pkg::OFF_SCAN, 32'h1);
      wr(inc_dec_pkg::OFF_SCAN, 32'h1);
      rdchk("edge once", inc_dec_pkg::OFF_OPERAND_LO, 32'h000c);
      // nineteen valid write-backs so far; the three bad bcd operands are not counted
      rdchk("exec count", inc_dec_pkg::OFF_EXEC_COUNT, 32'h0000_0013);
      $display("test level and edge done");
   endtask
   initial begin
      errors = 0;
      checks_done = 0;
      nrst = 1'b0;
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_reset;
      t_binary;
      t_bcd;
      t_invalid_irq;
      t_level_edge;
      finish_test;
   end
   always @(posedge ref_clk) begin
      if (bus_timeout === 1'b1) begin
         errors++;
         finish_test;
      end
   end
endmodule
